// [hw/occ_defines.svh]
/*
  Address map, field positions, reset values and action codes of the
  four-channel output compare block.
  Assumes an 8-bit register port with a 4-bit address.
*/
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

`define OCC_ADDR_W        4
`define OCC_DATA_W        8
`define OCC_CNT_W         16
`define OCC_NUM_CH        4

// Status/control registers at base + channel
`define OCC_ADDR_SC_BASE  4'h0
// Compare bytes at base + 2*channel (high), + 1 (low)
`define OCC_ADDR_CMP_BASE 4'h4
`define OCC_ADDR_LAST     4'hB

`define OCC_SC_RESET      8'h00
`define OCC_BIT_FLAG      7

`define OCC_ELS_OFF       2'h0
`define OCC_ELS_TOGGLE    2'h1
`define OCC_ELS_CLEAR     2'h2
`define OCC_ELS_SET       2'h3

`define OCC_PIN_RESET     1'h1

`endif

// [hw/occ_pkg.sv]
/*
  Types shared by the output compare block.
  Assumes occ_defines.svh is on the include path.
*/
package occ_pkg;

  // Status/control layout, bit 7 down to bit 0
  typedef struct packed {
    logic       flag;
    logic       irq_en;
    logic       buf_sel;
    logic       mode_a;
    logic [1:0] els;
    logic       tov;
    logic       full_duty;
  } occ_ctrl_type;

  // Which register of a buffered pair drives the comparator
  typedef enum logic {
    OCC_SRC_LOWER = 1'b0,
    OCC_SRC_UPPER = 1'b1
  } occ_src_type;

endpackage : occ_pkg

// [hw/occ_pin_ctrl.sv]
/*
  Pin driver of one compare channel: preset level, match action,
  toggle on overflow and full duty force.
  Assumes match and overflow are one-cycle pulses on CLK_IN.
*/
`timescale 1ns/1ns
`include "occ_defines.svh"

module occ_pin_ctrl
  import occ_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  occ_ctrl_type      ctrl_in,
  input  wire logic         connected_in,
  input  wire logic         match_in,
  input  wire logic         overflow_in,
  output logic              pin_out,
  output logic              oe_out
);

  logic pin_q;

  assign pin_out = pin_q;
  // Pin left to the port while edge/level is off or the pair owns it
  assign oe_out  = connected_in && (ctrl_in.els != `OCC_ELS_OFF);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= `OCC_PIN_RESET;
    end else if (ctrl_in.els == `OCC_ELS_OFF) begin
      pin_q <= ~ctrl_in.mode_a;
    end else if (ctrl_in.full_duty) begin
      pin_q <= 1'b1;
    end else if (match_in) begin
      case (ctrl_in.els)
        `OCC_ELS_TOGGLE: pin_q <= ~pin_q;
        `OCC_ELS_CLEAR:  pin_q <= 1'b0;
        `OCC_ELS_SET:    pin_q <= 1'b1;
        default:         pin_q <= pin_q;
      endcase
    end else if (ctrl_in.tov && overflow_in) begin
      pin_q <= ~pin_q;
    end
  end

endmodule // occ_pin_ctrl

// [hw/occ_output_compare.sv]
/*
  Four-channel output compare unit with buffered pairs 0/1 and 2/3.
  Assumes a free-running 16-bit counter and its overflow pulse from
  logic on CLK_IN, and an 8-bit register port with one-cycle strobes.
*/
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "occ_defines.svh"

module occ_output_compare
  import occ_pkg::*;
(
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_N_IN,
  input  wire logic [`OCC_ADDR_W-1:0]  ADDR_IN,
  input  wire logic [`OCC_DATA_W-1:0]  WR_DATA_IN,
  input  wire logic                    WR_IN,
  input  wire logic                    RD_IN,
  output logic      [`OCC_DATA_W-1:0]  RD_DATA_OUT,
  input  wire logic [`OCC_CNT_W-1:0]   COUNTER_IN,
  input  wire logic                    COUNTER_OVF_IN,
  output logic      [`OCC_NUM_CH-1:0]  CH_PIN_OUT,
  output logic      [`OCC_NUM_CH-1:0]  CH_PIN_OE_OUT,
  output logic      [`OCC_NUM_CH-1:0]  IRQ_OUT
);

  // Address of a status/control register
  function automatic logic [`OCC_ADDR_W-1:0] sc_addr(input int ch);
    sc_addr = `OCC_ADDR_SC_BASE + `OCC_ADDR_W'(ch);
  endfunction

  // Address of a compare byte, low selects the low byte
  function automatic logic [`OCC_ADDR_W-1:0] cmp_addr(input int ch,
                                                      input logic low);
    cmp_addr = `OCC_ADDR_CMP_BASE + `OCC_ADDR_W'(2 * ch)
               + `OCC_ADDR_W'(low);
  endfunction

  // Channel is set up as an output compare
  function automatic logic oc_mode(input occ_ctrl_type c,
                                   input logic buffered);
    oc_mode = (c.els != `OCC_ELS_OFF) && (buffered || c.mode_a);
  endfunction

  occ_ctrl_type                 ctrl_q [`OCC_NUM_CH];
  logic [`OCC_CNT_W-1:0]        cmp_q  [`OCC_NUM_CH];
  logic [`OCC_NUM_CH-1:0]       inhibit_q;
  logic [`OCC_NUM_CH-1:0]       arm_q;
  occ_src_type                  src_q  [2];
  occ_src_type                  last_q [2];
  logic [1:0]                   buf_prev_q;
  logic [`OCC_DATA_W-1:0]       rd_data_q;

  logic [`OCC_NUM_CH-1:0]       wr_sc;
  logic [`OCC_NUM_CH-1:0]       rd_sc;
  logic [`OCC_NUM_CH-1:0]       wr_hi;
  logic [`OCC_NUM_CH-1:0]       wr_lo;
  logic [`OCC_NUM_CH-1:0]       match;
  logic [`OCC_NUM_CH-1:0]       connected;
  logic [1:0]                   pair_buf;
  logic [`OCC_CNT_W-1:0]        act_val [2];
  logic [1:0]                   act_inh;
  occ_ctrl_type                 wr_fields;

  // Write data seen through the status/control layout
  assign wr_fields = WR_DATA_IN;

  always_comb begin
    for (int i = 0; i < `OCC_NUM_CH; i++) begin
      wr_sc[i] = WR_IN && (ADDR_IN == sc_addr(i));
      rd_sc[i] = RD_IN && (ADDR_IN == sc_addr(i));
      wr_hi[i] = WR_IN && (ADDR_IN == cmp_addr(i, 1'b0));
      wr_lo[i] = WR_IN && (ADDR_IN == cmp_addr(i, 1'b1));
    end
  end

  // Active compare source of each lower channel
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pair_buf[p] = ctrl_q[2 * p].buf_sel;
      if (pair_buf[p] && (src_q[p] == OCC_SRC_UPPER)) begin
        act_val[p] = cmp_q[2 * p + 1];
        act_inh[p] = inhibit_q[2 * p + 1];
      end else begin
        act_val[p] = cmp_q[2 * p];
        act_inh[p] = inhibit_q[2 * p];
      end
    end
  end

  // Comparators; partner channels fall silent when paired
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      match[2 * p] = oc_mode(ctrl_q[2 * p], pair_buf[p])
                     && !act_inh[p]
                     && (act_val[p] == COUNTER_IN);
      match[2 * p + 1] = !pair_buf[p]
                         && oc_mode(ctrl_q[2 * p + 1], 1'b0)
                         && !inhibit_q[2 * p + 1]
                         && (cmp_q[2 * p + 1] == COUNTER_IN);
      connected[2 * p]     = 1'b1;
      connected[2 * p + 1] = !pair_buf[p];
    end
  end

  // Compare storage, undefined after reset
  always_ff @(posedge CLK_IN) begin
    for (int i = 0; i < `OCC_NUM_CH; i++) begin
      if (wr_hi[i]) begin
        cmp_q[i][`OCC_CNT_W-1:`OCC_DATA_W] <= WR_DATA_IN;
      end
      if (wr_lo[i]) begin
        cmp_q[i][`OCC_DATA_W-1:0] <= WR_DATA_IN;
      end
    end
  end

  // Compare hold from high byte write until low byte write
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      inhibit_q <= '0;
    end else begin
      for (int i = 0; i < `OCC_NUM_CH; i++) begin
        if (wr_lo[i]) begin
          inhibit_q[i] <= 1'b0;
        end else if (wr_hi[i]) begin
          inhibit_q[i] <= 1'b1;
        end
      end
    end
  end

  // Control fields; flag handled below, partners hold no pair bit
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < `OCC_NUM_CH; i++) begin
        ctrl_q[i] <= `OCC_SC_RESET;
      end
    end else begin
      for (int i = 0; i < `OCC_NUM_CH; i++) begin
        if (wr_sc[i]) begin
          ctrl_q[i].irq_en    <= wr_fields.irq_en;
          ctrl_q[i].buf_sel   <= wr_fields.buf_sel && (i % 2 == 0);
          ctrl_q[i].mode_a    <= wr_fields.mode_a;
          ctrl_q[i].els       <= wr_fields.els;
          ctrl_q[i].tov       <= wr_fields.tov;
          ctrl_q[i].full_duty <= wr_fields.full_duty;
        end
        if (match[i]) begin
          ctrl_q[i].flag <= 1'b1;
        end else if (wr_sc[i] && arm_q[i]
                     && !wr_fields.flag) begin
          ctrl_q[i].flag <= 1'b0;
        end
      end
    end
  end

  // Clear sequence: read with flag set arms, any new match disarms
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      arm_q <= '0;
    end else begin
      for (int i = 0; i < `OCC_NUM_CH; i++) begin
        if (match[i] || wr_sc[i]) begin
          arm_q[i] <= 1'b0;
        end else if (rd_sc[i] && ctrl_q[i].flag) begin
          arm_q[i] <= 1'b1;
        end
      end
    end
  end

  // Buffered pair source selection
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      src_q      <= '{OCC_SRC_LOWER, OCC_SRC_LOWER};
      last_q     <= '{OCC_SRC_LOWER, OCC_SRC_LOWER};
      buf_prev_q <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        buf_prev_q[p] <= pair_buf[p];
        if (pair_buf[p] && !buf_prev_q[p]) begin
          src_q[p]  <= OCC_SRC_LOWER;
          last_q[p] <= OCC_SRC_LOWER;
        end else begin
          if (wr_hi[2 * p + 1] || wr_lo[2 * p + 1]) begin
            last_q[p] <= OCC_SRC_UPPER;
          end else if (wr_hi[2 * p] || wr_lo[2 * p]) begin
            last_q[p] <= OCC_SRC_LOWER;
          end
          if (COUNTER_OVF_IN && pair_buf[p]) begin
            src_q[p] <= last_q[p];
          end
        end
      end
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_data_q <= '0;
    end else if (RD_IN) begin
      rd_data_q <= '0;
      for (int i = 0; i < `OCC_NUM_CH; i++) begin
        if (ADDR_IN == sc_addr(i)) begin
          rd_data_q <= ctrl_q[i];
        end
        if (ADDR_IN == cmp_addr(i, 1'b0)) begin
          rd_data_q <= cmp_q[i][`OCC_CNT_W-1:`OCC_DATA_W];
        end
        if (ADDR_IN == cmp_addr(i, 1'b1)) begin
          rd_data_q <= cmp_q[i][`OCC_DATA_W-1:0];
        end
      end
    end
  end

  assign RD_DATA_OUT = rd_data_q;

  // CPU requests only; no DMA request path exists
  always_comb begin
    for (int i = 0; i < `OCC_NUM_CH; i++) begin
      // Paired partner register is disabled, so it raises nothing
      IRQ_OUT[i] = ctrl_q[i].flag && ctrl_q[i].irq_en
                   && connected[i];
    end
  end

  for (genvar g = 0; g < `OCC_NUM_CH; g++) begin : g_pin
    occ_pin_ctrl u_pin (
      .clk_in       (CLK_IN),
      .rst_n_in     (RST_N_IN),
      .ctrl_in      (ctrl_q[g]),
      .connected_in (connected[g]),
      .match_in     (match[g]),
      .overflow_in  (COUNTER_OVF_IN),
      .pin_out      (CH_PIN_OUT[g]),
      .oe_out       (CH_PIN_OE_OUT[g])
    );
  end

  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence partner_write_s;
    pair_buf[0] && src_q[0] == OCC_SRC_LOWER && wr_lo[1]
      && !COUNTER_OVF_IN;
  endsequence

  sequence no_overflow_s;
    !COUNTER_OVF_IN;
  endsequence

  sequence clear_race_s;
    match[0] && wr_sc[0] && arm_q[0] && !WR_DATA_IN[`OCC_BIT_FLAG];
  endsequence

  flag_on_match_a: assert property (
    match[0] |=> ctrl_q[0].flag)
    else $error("flag not set after match");

  match_cause_a: assert property (
    match[0] |-> (COUNTER_IN == act_val[0]) && !act_inh[0])
    else $error("match without equal value");

  write_hold_a: assert property (
    wr_hi[1] && !pair_buf[0] ##1 !wr_lo[1] |-> !match[1])
    else $error("match during split write");

  irq_follow_a: assert property (
    match[0] && ctrl_q[0].irq_en && !wr_sc[0] |=> IRQ_OUT[0])
    else $error("request missing after match");

  irq_drop_a: assert property (
    $fell(ctrl_q[0].flag) |-> !IRQ_OUT[0])
    else $error("request stands without flag");

  pin_toggle_a: assert property (
    match[0] && ctrl_q[0].els == `OCC_ELS_TOGGLE
      && !ctrl_q[0].full_duty |=> CH_PIN_OUT[0] != $past(CH_PIN_OUT[0]))
    else $error("pin did not toggle");

  pin_clear_a: assert property (
    match[1] && ctrl_q[1].els == `OCC_ELS_CLEAR
      && !ctrl_q[1].full_duty && !wr_sc[1] |=> !CH_PIN_OUT[1])
    else $error("pin not driven low");

  pair_release_a: assert property (
    pair_buf[0] |-> !CH_PIN_OE_OUT[1] && !match[1])
    else $error("partner pin still driven");

  partner_irq_a: assert property (
    pair_buf[0] |-> !IRQ_OUT[1])
    else $error("paired partner raised a request");

  partner_wait_a: assert property (
    partner_write_s ##1 no_overflow_s |=> src_q[0] == OCC_SRC_LOWER)
    else $error("partner active before overflow");

  overflow_swap_a: assert property (
    COUNTER_OVF_IN && pair_buf[0] && buf_prev_q[0]
      |=> src_q[0] == $past(last_q[0]))
    else $error("wrong source after overflow");

  clear_race_a: assert property (
    clear_race_s |=> ctrl_q[0].flag)
    else $error("flag cleared over new match");

  storage_read_a: assert property (
    RD_IN && ADDR_IN == cmp_addr(3, 1'b1)
      |=> RD_DATA_OUT == $past(cmp_q[3][`OCC_DATA_W-1:0]))
    else $error("compare byte read wrong");

  full_duty_a: assert property (
    ctrl_q[2].els != `OCC_ELS_OFF && ctrl_q[2].full_duty |=> CH_PIN_OUT[2])
    else $error("pin not forced high");

  preset_level_a: assert property (
    ctrl_q[0].els == `OCC_ELS_OFF
      |-> !CH_PIN_OE_OUT[0] ##1 CH_PIN_OUT[0] == !$past(ctrl_q[0].mode_a))
    else $error("preset level or pin release wrong");

endmodule // occ_output_compare

// [verif/occ_cnt_model.sv]
/*
  Counter model on the far side of the compare block.
  Assumes the bench drives run, clear and modulo on CLK_IN.
*/
`timescale 1ns/1ns

module occ_cnt_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        run_in,
  input  wire logic        clear_in,
  input  wire logic [15:0] modulo_in,
  output logic      [15:0] cnt_out,
  output logic             ovf_out
);
  logic [15:0] cnt_q;
  logic        ovf_q;

  assign cnt_out = cnt_q;
  assign ovf_out = ovf_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 16'h0000;
      ovf_q <= 1'b0;
    end else if (clear_in) begin  // Stop and reset
      cnt_q <= 16'h0000;
      ovf_q <= 1'b0;
    end else if (run_in && cnt_q == modulo_in) begin
      cnt_q <= 16'h0000;
      ovf_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {15'h0000, run_in};
      ovf_q <= 1'b0;
    end
  end
endmodule // occ_cnt_model

// [verif/test_output_compare_channels.sv]
/*
  Self-checking bench of the output compare block.
  Assumes occ_defines.svh on the include path and occ_cnt_model.
*/
`timescale 1ns/1ns
`include "occ_defines.svh"
`define CHK(N, E, G) begin cmp_count++; if ((G) !== (E)) begin \
  bad_count++; $display("mismatch %s exp %0h got %0h", N, E, G); end end

module test_output_compare_channels;
  logic        clk, rst_n, wr, rd, run, clr, pin_s, p;
  logic [3:0]  addr, pin, oe, irq;
  logic [7:0]  wdata, rdata, d;
  logic [15:0] cnt, cnt_s, v;
  logic [15:0] exp_cmp [4];
  logic        ovf;
  int          bad_count, cmp_count, i;
  logic [15:0] log_q [$];
  logic [15:0] exp_q [$];

  occ_output_compare u_dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_DATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata), .COUNTER_IN(cnt),
    .COUNTER_OVF_IN(ovf), .CH_PIN_OUT(pin), .CH_PIN_OE_OUT(oe),
    .IRQ_OUT(irq));

  occ_cnt_model u_cnt (
    .clk_in(clk), .rst_n_in(rst_n), .run_in(run), .clear_in(clr),
    .modulo_in(16'h003F), .cnt_out(cnt), .ovf_out(ovf));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counter value of each cycle in which pin 0 was switched
  always @(posedge clk) begin
    #1;
    if (pin[0] !== pin_s) log_q.push_back(cnt_s);
    pin_s = pin[0];
    cnt_s = cnt;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] dt);
    @(posedge clk);
    addr <= a; wdata <= dt; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] dt);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 dt = rdata;
  endtask

  task automatic wr_cmp(input int ch, input logic [15:0] val);
    wr_reg(4'(4 + 2 * ch), val[15:8]);
    wr_reg(4'(5 + 2 * ch), val[7:0]);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cnt_stop();
    @(posedge clk);
    run <= 1'b0; clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic cnt_go();
    @(posedge clk);
    run <= 1'b1;
  endtask

  task automatic wait_irq(input int ch);
    for (i = 0; i < 200 && irq[ch] !== 1'b1; i++) cycles(1);
    `CHK("irq", 1'b1, irq[ch])
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #40000;
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; run = 1'b0; clr = 1'b0;
    addr = 4'h0; wdata = 8'h00; bad_count = 0; cmp_count = 0;
    void'($urandom(32'h43CD8157));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cycles(2);
    `CHK("pin", 4'hF, pin)
    `CHK("oe", 4'h0, oe)
    for (int ch = 0; ch < 4; ch++) begin
      rd_reg(4'(ch), d);
      `CHK("status", 8'h00, d)
    end
    wr_reg(4'hC, 8'hFF);
    rd_reg(4'hC, d);
    `CHK("unmapped", 8'h00, d)
    $display("test reset done");

    for (int ch = 0; ch < 4; ch++) begin
      exp_cmp[ch] = 16'($urandom);
      wr_cmp(ch, exp_cmp[ch]);
    end
    for (int ch = 0; ch < 4; ch++) begin
      rd_reg(4'(4 + 2 * ch), d);
      `CHK("cmp_hi", exp_cmp[ch][15:8], d)
      rd_reg(4'(5 + 2 * ch), d);
      `CHK("cmp_lo", exp_cmp[ch][7:0], d)
    end
    $display("test storage done");

    for (int code = 1; code < 4; code++) begin
      p = (code == 2) ? 1'b0 : 1'b1;
      cnt_stop();
      wr_reg(4'(code - 1), {3'h0, p, 4'h0});
      cycles(2);
      `CHK("preset", ~p, pin[code-1])
      `CHK("oe_off", 1'b0, oe[code-1])
      v = 16'(4 + $urandom_range(50));
      wr_cmp(code - 1, v);
      wr_reg(4'(code - 1), 8'(8'h50 | (code << 2)));
      cnt_go();
      wait_irq(code - 1);
      cnt_stop();
      `CHK("pin_act", p, pin[code-1])
      `CHK("oe_on", 1'b1, oe[code-1])
      rd_reg(4'(code - 1), d);
      `CHK("flag", 1'b1, d[7])
      wr_reg(4'(code - 1), d & 8'h7F);
      cycles(1);
      `CHK("irq_clr", 1'b0, irq[code-1])
    end
    $display("test modes done");

    cnt_stop();
    wr_cmp(3, 16'h0010);
    wr_reg(4'h3, 8'h54);
    wr_reg(4'hA, 8'h00);
    cnt_go();
    cycles(140);
    `CHK("inhibit", 1'b0, irq[3])
    wr_reg(4'hB, 8'h10);
    wait_irq(3);
    cnt_stop();
    wr_reg(4'h3, 8'h20);
    rd_reg(4'h3, d);
    `CHK("sc3", 8'h00, d & 8'h7F)
    $display("test inhibit done");

    wr_reg(4'h0, 8'h64);
    wr_cmp(0, 16'h0008);
    wr_cmp(1, 16'h0020);
    log_q.delete();
    exp_q = '{16'h0008, 16'h0020, 16'h0030};
    cnt_go();
    for (i = 0; i < 300 && log_q.size() < 2; i++) cycles(1);
    `CHK("oe1", 1'b0, oe[1])
    `CHK("irq1", 1'b0, irq[1])
    wr_cmp(0, 16'h0030); // Inactive register only
    for (i = 0; i < 300 && log_q.size() < 3; i++) cycles(1);
    for (int k = 0; k < 3; k++) begin
      `CHK("match_at", exp_q[k], log_q[k])
    end
    $display("test buffered done");

    cnt_stop();
    wr_cmp(2, 16'h0010);
    wr_reg(4'h2, 8'h19);
    cnt_go();
    cycles(140);
    `CHK("full_duty", 1'b1, pin[2])
    cnt_stop();
    wr_cmp(2, 16'hFFFF);
    wr_reg(4'h2, 8'h1E);
    cnt_go();
    for (i = 0; i < 200 && ovf !== 1'b1; i++) cycles(1);
    p = pin[2];
    cycles(1);
    `CHK("tov", ~p, pin[2])
    $display("test overflow done");
    stop_test();
  end
endmodule // test_output_compare_channels
